// File: rtl/adsc_cfg.svh
/*
 * Constants of the converter select, clock and reference control block:
 * register offsets, field positions, reset values, encodings and counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// ------------------------------------------------------------
// Bus geometry
// ------------------------------------------------------------
`define ADSC_ADDR_W        8
`define ADSC_DATA_W        32
`define ADSC_RESP_OKAY     2'h0
`define ADSC_RESP_SLVERR   2'h2

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADSC_OFF_MAIN      8'h00
`define ADSC_OFF_INCLK     8'h04
`define ADSC_OFF_REFSEL    8'h08
`define ADSC_OFF_PINS      8'h0c
`define ADSC_OFF_RES_HI    8'h10
`define ADSC_OFF_RES_LO    8'h14
`define ADSC_OFF_IRQ       8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ADSC_MAIN_START    7
`define ADSC_MAIN_BUSY     6
`define ADSC_MAIN_POWER    5
`define ADSC_MAIN_FMT      4
`define ADSC_INCLK_SRC_LSB 5
`define ADSC_IRQ_FLAG      0
`define ADSC_IRQ_EN        1
`define ADSC_REF_AMP       7
`define ADSC_REF_BG        6
`define ADSC_REF_EXTPIN    5
`define ADSC_REF_OUTPIN    4

// ------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------
`define ADSC_PINS_RST      8'hff
`define ADSC_SRC_EXT0      3'h0
`define ADSC_SRC_ANALOG_SUPPLY      3'h1
`define ADSC_SRC_HALF      3'h2
`define ADSC_SRC_QUART     3'h3
`define ADSC_SRC_EXT1      3'h4
`define ADSC_REF_EXT_X1    4'h1
`define ADSC_REF_EXT_X4    4'h4
`define ADSC_REF_BG_X2     4'ha
`define ADSC_REF_BG_X4     4'hc
`define ADSC_REF_BAD       4'h9

// ------------------------------------------------------------
// Conversion timing in converter clock cycles, and divider counter width
// ------------------------------------------------------------
`define ADSC_SAMPLE_CYC    4'h4
`define ADSC_CONV_CYC      4'hc
`define ADSC_LAST_CYC      4'hf
`define ADSC_DIV_W         7

`endif

// File: rtl/adsc_pkg.sv
/*
 * Types of the converter select, clock and reference control block.
 * Assumes adsc_cfg.svh is on the include path.
 */
`include "adsc_cfg.svh"

package adsc_pkg;

	// ------------------------------------------------------------
	// Bus carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic                      awvalid;
		logic [`ADSC_ADDR_W-1:0]   awaddr;
		logic                      wvalid;
		logic [`ADSC_DATA_W-1:0]   wdata;
		logic [3:0]                wstrb;
		logic                      bready;
		logic                      arvalid;
		logic [`ADSC_ADDR_W-1:0]   araddr;
		logic                      rready;
	} adsc_axi_req_t;

	typedef struct packed {
		logic                      awready;
		logic                      wready;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      arready;
		logic                      rvalid;
		logic [`ADSC_DATA_W-1:0]   rdata;
		logic [1:0]                rresp;
	} adsc_axi_rsp_t;

	// ------------------------------------------------------------
	// Controls towards the analog macro
	// ------------------------------------------------------------
	typedef struct packed {
		logic       power_on;       // converter_power_on
		logic       ext_path_on;    // external channel path connected
		logic [2:0] ext_channel;    // analog_input_pins index
		logic       src_analog_supply;       // analog_supply as input
		logic       src_half;       // analog_supply / 2
		logic       src_quarter;    // analog_supply / 4
		logic [7:0] analog_pin_enable;
		logic       ref_analog_supply;       // reference from analog_supply
		logic       ref_ext;        // reference from external pin
		logic       ref_bg;         // reference from bandgap_voltage
		logic [1:0] ref_gain;       // gain minus one
		logic       ref_amp_on;     // reference_amplifier power
		logic       bandgap_on;
		logic       ext_ref_pin_enable;
		logic       ref_out_pin_enable;
	} adsc_ana_ctrl_t;

	// Reference decode result
	typedef struct packed {
		logic       analog_supply;
		logic       ext;
		logic       bg;
		logic [1:0] gain;
	} adsc_ref_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ADSC_SEQ_IDLE = 2'b00,
		ADSC_SEQ_RUN  = 2'b01
	} adsc_seq_st_t;

endpackage : adsc_pkg

// File: rtl/adsc_clk_div.sv
/*
 * Converter clock divider: a free-running system clock counter whose
 * terminal count follows the divide select, giving one tick per
 * converter clock period. Assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adsc_cfg.svh"

module adsc_clk_div (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Divide select
	input  wire logic [2:0]  div_sel,
	// Converter clock tick
	output logic             conv_tick
);
	import adsc_pkg::*;

	typedef struct packed {
		logic [`ADSC_DIV_W-1:0] cnt;
	} adsc_div_st_t;

	adsc_div_st_t s_q;
	adsc_div_st_t s_d;

	// Low mask of 2^sel - 1 marks the terminal count
	function automatic logic [`ADSC_DIV_W-1:0] div_mask(input logic [2:0] sel);
		div_mask = ~({`ADSC_DIV_W{1'b1}} << sel);
	endfunction : div_mask

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// divide by 1 to 128
	always_comb begin
		s_d       = s_q;
		s_d.cnt   = s_q.cnt + 7'h01;
		conv_tick = (s_q.cnt & div_mask(div_sel)) == div_mask(div_sel);
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : adsc_clk_div

`default_nettype wire

// File: rtl/adsc_seq.sv
/*
 * Conversion sequencer: sampling then conversion phases counted in
 * converter clock ticks. Assumes launch is a one-cycle pulse and that
 * hold stays high while the converter must stay in reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adsc_cfg.svh"

module adsc_seq (
	// Clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// Control
	input  wire logic  conv_tick,
	input  wire logic  hold,
	input  wire logic  launch,
	// Status
	output logic       busy,
	output logic       sampling,
	output logic       converting,
	output logic       done
);
	import adsc_pkg::*;

	typedef struct packed {
		adsc_seq_st_t st;
		logic [3:0]   cnt;
		logic         done;
	} adsc_sq_st_t;

	adsc_sq_st_t s_q;
	adsc_sq_st_t s_d;

	// ------------------------------------------------------------
	// Phase sequencing
	// ------------------------------------------------------------
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			ADSC_SEQ_IDLE: begin
				if (launch && !hold) begin
					s_d.st  = ADSC_SEQ_RUN;
					s_d.cnt = 4'h0;
				end
			end
			ADSC_SEQ_RUN: begin
				if (conv_tick) begin
					s_d.cnt = s_q.cnt + 4'h1;
					if (s_q.cnt == `ADSC_LAST_CYC) begin
						s_d.st   = ADSC_SEQ_IDLE;
						s_d.done = 1'b1;
					end
				end
			end
			default: s_d.st = ADSC_SEQ_IDLE;
		endcase
		if (hold) begin
			s_d.st   = ADSC_SEQ_IDLE;
			s_d.done = 1'b0;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q    <= '0;
			s_q.st <= ADSC_SEQ_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Status outputs
	// busy while running
	assign busy       = (s_q.st == ADSC_SEQ_RUN);
	assign sampling   = busy && (s_q.cnt < `ADSC_SAMPLE_CYC);
	assign converting = busy && !(s_q.cnt < `ADSC_SAMPLE_CYC);
	assign done       = s_q.done;

endmodule : adsc_seq

`default_nettype wire

// File: rtl/adsc_ctrl.sv
/*
 * Converter select, clock and reference control with an AXI4-Lite
 * register slave. Holds input source selection, pin enables, clock
 * divide, reference selection, start handshake, busy and completion
 * flag. Assumes one clock, a synchronous active-low reset, and an
 * analog macro that presents its result when a conversion finishes.
 */
// Chosen here: the AXI4-Lite register port and the register addresses.
// Behaviour
// - codes 000, 100 route external channel
// - 001 supply, 010 half, 011 quarter
// - internal source disconnects external channel path
// - divide select gives divide 1 to 128
// - amplifier enable bit powers reference amplifier
// - bandgap on when enabled or low-voltage functions
// - reference select decodes supply, external, bandgap
// - bandgap reference disconnects supply and pin paths
// - pin enable bits, all reset to one
// - start high then low begins conversion
// - start held high resets converter, clears busy
// - busy set on launch, cleared on finish
// - completion sets flag, interrupt when enabled
// - four sample plus twelve conversion cycles
// - power off clears result registers
`timescale 1ns/1ps
`default_nettype none
`include "adsc_cfg.svh"

module adsc_ctrl (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// Register bus
	input  wire adsc_pkg::adsc_axi_req_t axi_req,
	output adsc_pkg::adsc_axi_rsp_t     axi_rsp,
	// Low-voltage functions sharing the bandgap
	input  wire logic                   low_voltage_detect_en,
	input  wire logic                   low_voltage_reset_en,
	// Analog macro
	input  wire logic [11:0]            conv_data,
	output adsc_pkg::adsc_ana_ctrl_t    ana_ctrl,
	output logic                        conv_reset,
	output logic                        conv_tick,
	output logic                        conv_sampling,
	output logic                        conv_converting,
	// Completion interrupt
	output logic                        conv_irq
);
	import adsc_pkg::*;

	typedef struct packed {
		logic                    aw_held;
		logic [`ADSC_ADDR_W-1:0] aw_addr;
		logic                    w_held;
		logic [7:0]              w_byte;
		logic                    w_lane0;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [`ADSC_DATA_W-1:0] rdata;
		logic [1:0]              rresp;
		logic                    start;
		logic                    launch;
		logic                    power;
		logic                    fmt;
		logic [2:0]              ext_ch;
		logic [2:0]              src;
		logic [2:0]              ckdiv;
		logic [7:0]              refctl;
		logic [7:0]              pins;
		logic [11:0]             result;
		logic                    irq_flag;
		logic                    irq_en;
		adsc_ana_ctrl_t          ana;
	} adsc_ctrl_st_t;

	adsc_ctrl_st_t s_q;
	adsc_ctrl_st_t s_d;

	logic seq_busy;
	logic seq_done;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Reference source and gain from the select field
	function automatic adsc_ref_t ref_decode(input logic [3:0] sel);
		adsc_ref_t r;
		r = '0;
		if (sel >= `ADSC_REF_EXT_X1 && sel <= `ADSC_REF_EXT_X4) begin
			r.ext  = 1'b1;
			r.gain = 2'(sel - `ADSC_REF_EXT_X1);
		end else if (sel >= `ADSC_REF_BG_X2 && sel <= `ADSC_REF_BG_X4) begin
			r.bg   = 1'b1;
			r.gain = 2'(sel - `ADSC_REF_BG_X2 + 4'h1);
		end else begin
			r.analog_supply = 1'b1;
		end
		return r;
	endfunction : ref_decode

	// Whether the source code selects the external channel
	function automatic logic src_is_ext(input logic [2:0] src);
		return (src == `ADSC_SRC_EXT0) || (src == `ADSC_SRC_EXT1);
	endfunction : src_is_ext

	// Register read view
	function automatic logic [7:0] reg_read(input adsc_ctrl_st_t s,
	                                        input logic [`ADSC_ADDR_W-1:0] a,
	                                        input logic busy);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`ADSC_OFF_MAIN: begin
				v[`ADSC_MAIN_START] = s.start;
				v[`ADSC_MAIN_BUSY]  = busy;
				v[`ADSC_MAIN_POWER] = s.power;
				v[`ADSC_MAIN_FMT]   = s.fmt;
				v[2:0]              = s.ext_ch;
			end
			`ADSC_OFF_INCLK: v = {s.src, 2'h0, s.ckdiv};
			`ADSC_OFF_REFSEL: v = s.refctl;
			`ADSC_OFF_PINS: v = s.pins;
			`ADSC_OFF_RES_HI: v = s.fmt ? {4'h0, s.result[11:8]} : s.result[11:4];
			`ADSC_OFF_RES_LO: v = s.fmt ? s.result[7:0] : {s.result[3:0], 4'h0};
			`ADSC_OFF_IRQ: begin
				v[`ADSC_IRQ_FLAG] = s.irq_flag;
				v[`ADSC_IRQ_EN]   = s.irq_en;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// Known register offsets
	function automatic logic reg_hit(input logic [`ADSC_ADDR_W-1:0] a);
		return (a == `ADSC_OFF_MAIN) || (a == `ADSC_OFF_INCLK) ||
		       (a == `ADSC_OFF_REFSEL) || (a == `ADSC_OFF_PINS) ||
		       (a == `ADSC_OFF_RES_HI) || (a == `ADSC_OFF_RES_LO) ||
		       (a == `ADSC_OFF_IRQ);
	endfunction : reg_hit

	// ------------------------------------------------------------
	// Bus, registers and control
	// ------------------------------------------------------------
	always_comb begin
		adsc_ref_t rf;
		rf  = '0;
		s_d = s_q;
		s_d.launch = 1'b0;

		// Channel readiness
		axi_rsp.awready = !s_q.aw_held && !s_q.bvalid;
		axi_rsp.wready  = !s_q.w_held && !s_q.bvalid;
		axi_rsp.arready = !s_q.rvalid;
		axi_rsp.bvalid  = s_q.bvalid;
		axi_rsp.bresp   = s_q.bresp;
		axi_rsp.rvalid  = s_q.rvalid;
		axi_rsp.rdata   = s_q.rdata;
		axi_rsp.rresp   = s_q.rresp;

		// Capture address and data in either order
		if (axi_req.awvalid && axi_rsp.awready) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			s_d.w_held  = 1'b1;
			s_d.w_byte  = axi_req.wdata[7:0];
			s_d.w_lane0 = axi_req.wstrb[0];
		end
		if (s_q.bvalid && axi_req.bready) begin
			s_d.bvalid = 1'b0;
		end

		// Write once both halves are held
		if (s_q.aw_held && s_q.w_held) begin
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = reg_hit(s_q.aw_addr) ? `ADSC_RESP_OKAY : `ADSC_RESP_SLVERR;
			if (s_q.w_lane0) begin
				unique case (s_q.aw_addr)
					`ADSC_OFF_MAIN: begin
						s_d.start  = s_q.w_byte[`ADSC_MAIN_START];
						s_d.power  = s_q.w_byte[`ADSC_MAIN_POWER];
						s_d.fmt    = s_q.w_byte[`ADSC_MAIN_FMT];
						s_d.ext_ch = s_q.w_byte[2:0];
						s_d.launch = s_q.start && !s_q.w_byte[`ADSC_MAIN_START] &&
						             s_q.w_byte[`ADSC_MAIN_POWER];
					end
					`ADSC_OFF_INCLK: begin
						s_d.src   = s_q.w_byte[7:`ADSC_INCLK_SRC_LSB];
						s_d.ckdiv = s_q.w_byte[2:0];
					end
					`ADSC_OFF_REFSEL: s_d.refctl = s_q.w_byte;
					`ADSC_OFF_PINS: s_d.pins = s_q.w_byte;
					`ADSC_OFF_IRQ: begin
						s_d.irq_en = s_q.w_byte[`ADSC_IRQ_EN];
						if (s_q.w_byte[`ADSC_IRQ_FLAG]) begin
							s_d.irq_flag = 1'b0;
						end
					end
					default: s_d.bresp = s_q.bresp;
				endcase
				if (!reg_hit(s_q.aw_addr)) begin
					s_d.bresp = `ADSC_RESP_SLVERR;
				end
			end
		end

		// Read path
		if (s_q.rvalid && axi_req.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = {24'h000000, reg_read(s_q, axi_req.araddr, seq_busy)};
			s_d.rresp  = reg_hit(axi_req.araddr) ? `ADSC_RESP_OKAY : `ADSC_RESP_SLVERR;
		end

		if (seq_done) begin
			s_d.irq_flag = 1'b1;
			s_d.result   = conv_data;
		end
		if (!s_d.power) begin
			s_d.result = 12'h000;
		end

		// Analog controls
		// external channel codes
		s_d.ana.power_on    = s_d.power;
		s_d.ana.ext_path_on = src_is_ext(s_d.src);
		s_d.ana.ext_channel = s_d.ext_ch;
		s_d.ana.src_analog_supply    = (s_d.src == `ADSC_SRC_ANALOG_SUPPLY);
		s_d.ana.src_half    = (s_d.src == `ADSC_SRC_HALF);
		s_d.ana.src_quarter = (s_d.src == `ADSC_SRC_QUART);
		s_d.ana.analog_pin_enable = s_d.pins;
		rf = ref_decode(s_d.refctl[3:0]);
		s_d.ana.ref_analog_supply = rf.analog_supply;
		s_d.ana.ref_ext  = rf.ext;
		s_d.ana.ref_bg   = rf.bg;
		s_d.ana.ref_gain = rf.gain;
		s_d.ana.ref_amp_on = s_d.refctl[`ADSC_REF_AMP];
		s_d.ana.bandgap_on = s_d.refctl[`ADSC_REF_BG] || low_voltage_detect_en ||
		                     low_voltage_reset_en;
		s_d.ana.ext_ref_pin_enable = s_d.refctl[`ADSC_REF_EXTPIN];
		s_d.ana.ref_out_pin_enable = s_d.refctl[`ADSC_REF_OUTPIN];
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q                       <= '0;
			s_q.pins                  <= `ADSC_PINS_RST;
			s_q.ana.analog_pin_enable <= `ADSC_PINS_RST;
			s_q.ana.ext_path_on       <= 1'b1;
			s_q.ana.ref_analog_supply          <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Converter clock and sequencer
	// ------------------------------------------------------------
	// converter clock source
	adsc_clk_div u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.div_sel   (s_q.ckdiv),
		.conv_tick (conv_tick)
	);

	adsc_seq u_seq (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.conv_tick  (conv_tick),
		.hold       (conv_reset),
		.launch     (s_q.launch),
		.busy       (seq_busy),
		.sampling   (conv_sampling),
		.converting (conv_converting),
		.done       (seq_done)
	);

	// Macro reset and interrupt
	assign conv_reset = s_q.start || !s_q.power;
	assign ana_ctrl   = s_q.ana;
	assign conv_irq   = s_q.irq_flag && s_q.irq_en;

endmodule : adsc_ctrl

`default_nettype wire

// File: sim/adsc_ctrl_props.sv
/*
 * Checker: concurrent assertions on the converter control ports.
 * Assumes a bind onto adsc_ctrl and the adsc_pkg types.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_ctrl_props (
	// Clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// Register bus
	input wire adsc_pkg::adsc_axi_req_t  axi_req,
	input wire adsc_pkg::adsc_axi_rsp_t  axi_rsp,
	// Low-voltage functions
	input wire logic                     low_voltage_detect_en,
	input wire logic                     low_voltage_reset_en,
	// Analog macro
	input wire logic [11:0]              conv_data,
	input wire adsc_pkg::adsc_ana_ctrl_t ana_ctrl,
	input wire logic                     conv_reset,
	input wire logic                     conv_tick,
	input wire logic                     conv_sampling,
	input wire logic                     conv_converting,
	input wire logic                     conv_irq
);
	import adsc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] samp_q;
	logic [3:0] conv_q;
	logic [7:0] gap_q;
	// ------------------------------------------------------------
	// Tick counters per phase and gap between ticks
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp_q <= 4'h0;
			conv_q <= 4'h0;
			gap_q  <= 8'h00;
		end else begin
			samp_q <= conv_sampling ? samp_q + {3'h0, conv_tick} : 4'h0;
			conv_q <= conv_converting ? conv_q + {3'h0, conv_tick} : 4'h0;
			gap_q  <= conv_tick ? 8'h00 : gap_q + 8'h01;
		end
	end
	property p_src_excl;
		$onehot0({ana_ctrl.ext_path_on, ana_ctrl.src_analog_supply, ana_ctrl.src_half, ana_ctrl.src_quarter});
	endproperty
	a_src_excl: assert property (p_src_excl) else $error("several sources at once");
	property p_int_off;
		(ana_ctrl.src_analog_supply || ana_ctrl.src_half || ana_ctrl.src_quarter) |-> !ana_ctrl.ext_path_on;
	endproperty
	a_int_off: assert property (p_int_off) else $error("external path left on");
	property p_bg_off;
		ana_ctrl.ref_bg |-> !ana_ctrl.ref_analog_supply && !ana_ctrl.ref_ext;
	endproperty
	a_bg_off: assert property (p_bg_off) else $error("supply or pin ref with bandgap");
	property p_bg_lv;
		(low_voltage_detect_en || low_voltage_reset_en) [*3] |-> ana_ctrl.bandgap_on;
	endproperty
	a_bg_lv: assert property (p_bg_lv) else $error("bandgap off while needed");
	property p_hold;
		conv_reset [*2] |-> !conv_sampling && !conv_converting;
	endproperty
	a_hold: assert property (p_hold) else $error("sequencer runs in reset");
	property p_launch;
		$rose(conv_sampling) |-> !conv_reset && ana_ctrl.power_on;
	endproperty
	a_launch: assert property (p_launch) else $error("launch without start fall");
	property p_samp4;
		$fell(conv_sampling) && conv_converting |-> samp_q == 4'h4;
	endproperty
	a_samp4: assert property (p_samp4) else $error("sampling tick count wrong");
	property p_conv12;
		$fell(conv_converting) && !conv_reset |-> conv_q == 4'hc;
	endproperty
	a_conv12: assert property (p_conv12) else $error("conversion tick count wrong");
	property p_pins_rst;
		$rose(aresetn) |-> ana_ctrl.analog_pin_enable == 8'hff && ana_ctrl.ref_analog_supply;
	endproperty
	a_pins_rst: assert property (p_pins_rst) else $error("reset values wrong");
	property p_tick_gap;
		gap_q < 8'h80;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("converter clock stopped");
	c_run: cover property ($fell(conv_converting) && !conv_reset);
	c_irq: cover property ($rose(conv_irq));
	c_div128: cover property (gap_q == 8'h7f);
endmodule : adsc_ctrl_props
`default_nettype wire

// File: sim/adsc_macro_model.sv
/*
 * Analog macro model: presents a fixed result from conversion until the
 * next macro reset, a changing pattern otherwise. Assumes the block's clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_macro_model #(
	parameter logic [11:0] RESULT = 12'ha5c
) (
	// Clock
	input wire logic   aclk,
	// Control from the block
	input wire logic   conv_reset,
	input wire logic   conv_converting,
	// Result
	output logic [11:0] conv_data
);
	logic [11:0] junk_q = 12'h000;
	logic        held_q = 1'b0;
	// Pattern that moves every cycle outside a conversion
	always_ff @(posedge aclk) begin
		junk_q <= junk_q + 12'h3a7;
	end
	// Result stays up after a run, the block captures it a cycle late
	always_ff @(posedge aclk) begin
		held_q <= !conv_reset && (conv_converting || held_q);
	end
	assign conv_data = ((conv_converting || held_q) && !conv_reset) ? RESULT : junk_q;
endmodule : adsc_macro_model
`default_nettype wire

// File: sim/adsc_ctrl_tb_top.sv
/*
 * Testbench: register bus tasks, select tables, divider, conversion.
 * Assumes the checker and macro model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adsc_cfg.svh"
module adsc_ctrl_tb_top;
	import adsc_pkg::*;
	logic           aclk;
	logic           aresetn;
	adsc_axi_req_t  req;
	adsc_axi_rsp_t  rsp;
	logic           lvd_en;
	logic           lvr_en;
	logic [11:0]    conv_data;
	adsc_ana_ctrl_t ana;
	logic           conv_reset;
	logic           conv_tick;
	logic           conv_samp;
	logic           conv_conv;
	logic           conv_irq;
	logic [31:0]    rd_q;
	logic [1:0]     rs_q;
	int             failures;
	int             num_checks;
	int             cyc;
	int             n;
	// {ext_path_on, analog_supply, half, quarter} per source code
	localparam logic [3:0] SRC_EXP [8] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h0, 4'h0, 4'h0};
	// {analog_supply, ext, bandgap} per reference code
	localparam logic [2:0] REF_EXP [16] = '{3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4,
		3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4, 3'h4};
	adsc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.low_voltage_detect_en(lvd_en), .low_voltage_reset_en(lvr_en), .conv_data(conv_data),
		.ana_ctrl(ana), .conv_reset(conv_reset), .conv_tick(conv_tick),
		.conv_sampling(conv_samp), .conv_converting(conv_conv), .conv_irq(conv_irq));
	adsc_macro_model i_macro (.aclk(aclk), .conv_reset(conv_reset), .conv_converting(conv_conv),
		.conv_data(conv_data));
	// Clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && rsp.awready) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!rsp.bvalid);
		rs_q = rsp.bresp;
		req.bready <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(posedge aclk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.rvalid);
		rd_q = rsp.rdata;
		rs_q = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		rd(a);
		chk(rd_q & m, exp);
	endtask : rchk
	task automatic wait_tick();
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!conv_tick);
	endtask : wait_tick
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		req = '0;
		aresetn = 1'b0;
		lvd_en = 1'b0;
		lvr_en = 1'b0;
		failures = 0;
		num_checks = 0;
		cyc = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`ADSC_OFF_PINS, 32'hff, 32'hffffffff);
		rchk(`ADSC_OFF_INCLK, 32'h0, 32'hffffffff);
		for (int i = 0; i < 8; i++) begin
			wr(`ADSC_OFF_MAIN, i);
			wr(`ADSC_OFF_INCLK, {24'h0, i[2:0], 5'h0});
			chk({ana.ext_path_on, ana.src_analog_supply, ana.src_half, ana.src_quarter}, SRC_EXP[i]);
			chk(ana.ext_channel, i);
		end
		wr(`ADSC_OFF_PINS, 32'h5a);
		chk(ana.analog_pin_enable, 32'h5a);
		wr(`ADSC_OFF_INCLK, 32'hffffffff);
		rchk(`ADSC_OFF_INCLK, 32'he7, 32'hffffffff);
		wr(8'h1c, 32'h1);
		chk(rs_q, `ADSC_RESP_SLVERR);
		rchk(8'h1c, 32'h0, 32'hffffffff);
		chk(rs_q, `ADSC_RESP_SLVERR);
		for (int i = 0; i < 16; i++) begin
			wr(`ADSC_OFF_REFSEL, 32'h80 | i);
			chk({ana.ref_analog_supply, ana.ref_ext, ana.ref_bg}, REF_EXP[i]);
			if (!REF_EXP[i][2]) chk(ana.ref_gain, REF_EXP[i][1] ? i - 1 : i - 9);
			chk(ana.ref_amp_on, 1'b1);
		end
		wr(`ADSC_OFF_REFSEL, 32'h30);
		chk({ana.ref_amp_on, ana.bandgap_on}, 2'b00);
		chk({ana.ext_ref_pin_enable, ana.ref_out_pin_enable}, 2'b11);
		lvd_en <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(ana.bandgap_on, 1'b1);
		lvd_en <= 1'b0;
		lvr_en <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(ana.bandgap_on, 1'b1);
		lvr_en <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(ana.bandgap_on, 1'b0);
		wr(`ADSC_OFF_REFSEL, 32'h40);
		chk(ana.bandgap_on, 1'b1);
		// divider sweep gives bandgap settling time
		for (int i = 0; i < 8; i++) begin
			wr(`ADSC_OFF_INCLK, i);
			repeat (2) wait_tick();
			wait_tick();
			chk(n, 1 << i);
		end
		wr(`ADSC_OFF_INCLK, 32'h1);
		wr(`ADSC_OFF_MAIN, 32'ha0);
		chk({conv_reset, ana.power_on}, 2'b11);
		rchk(`ADSC_OFF_MAIN, 32'h0, 32'h40);
		wr(`ADSC_OFF_MAIN, 32'h20);
		rchk(`ADSC_OFF_MAIN, 32'h40, 32'h40);
		do @(posedge aclk); while (conv_samp || conv_conv);
		repeat (3) @(posedge aclk);
		rchk(`ADSC_OFF_MAIN, 32'h0, 32'h40);
		rchk(`ADSC_OFF_RES_HI, 32'ha5, 32'hffffffff);
		rchk(`ADSC_OFF_RES_LO, 32'hc0, 32'hffffffff);
		rchk(`ADSC_OFF_IRQ, 32'h1, 32'h1);
		chk(conv_irq, 1'b0);
		wr(`ADSC_OFF_IRQ, 32'h2);
		chk(conv_irq, 1'b1);
		wr(`ADSC_OFF_IRQ, 32'h3);
		chk(conv_irq, 1'b0);
		wr(`ADSC_OFF_MAIN, 32'ha0);
		wr(`ADSC_OFF_MAIN, 32'h20);
		wr(`ADSC_OFF_MAIN, 32'ha0);
		chk({conv_samp, conv_conv}, 2'b00);
		rchk(`ADSC_OFF_MAIN, 32'h0, 32'h40);
		wr(`ADSC_OFF_MAIN, 32'h0);
		rchk(`ADSC_OFF_RES_HI, 32'h0, 32'hffffffff);
		rchk(`ADSC_OFF_RES_LO, 32'h0, 32'hffffffff);
		wr(`ADSC_OFF_MAIN, 32'h80);
		wr(`ADSC_OFF_MAIN, 32'h0);
		rchk(`ADSC_OFF_MAIN, 32'h0, 32'h40);
		complete_run();
	end
endmodule : adsc_ctrl_tb_top
bind adsc_ctrl adsc_ctrl_props i_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .low_voltage_detect_en(low_voltage_detect_en),
	.low_voltage_reset_en(low_voltage_reset_en), .conv_data(conv_data), .ana_ctrl(ana_ctrl),
	.conv_reset(conv_reset), .conv_tick(conv_tick), .conv_sampling(conv_sampling),
	.conv_converting(conv_converting), .conv_irq(conv_irq));
`default_nettype wire
